// file: design/serial_pkg.sv
// Purpose : Shared constants and types of the dual serial port block.
// Assumes : 8-bit special-function-register bus of the core, one clock.
// Notes   : Offsets are the core's register addresses.
package serial_pkg;

  // ******************************************************
  // Register addresses
  // ******************************************************
  localparam logic [7:0] ADDR_POWER_CTRL = 8'h87;
  localparam logic [7:0] ADDR_P0_CTRL    = 8'h98;
  localparam logic [7:0] ADDR_P0_BUF     = 8'h99;
  localparam logic [7:0] ADDR_P1_CTRL    = 8'h9B;
  localparam logic [7:0] ADDR_P1_BUF     = 8'h9C;
  localparam logic [7:0] ADDR_P1_REL_LO  = 8'h9D;
  localparam logic [7:0] ADDR_P0_REL_LO  = 8'hAA;
  localparam logic [7:0] ADDR_P0_REL_HI  = 8'hBA;
  localparam logic [7:0] ADDR_P1_REL_HI  = 8'hBB;
  localparam logic [7:0] ADDR_BAUD_SRC   = 8'hD8;

  // ******************************************************
  // Reset values
  // ******************************************************
  localparam logic [7:0] RST_BYTE   = 8'h00;
  localparam logic [9:0] RST_RELOAD = 10'h3D9;

  // ******************************************************
  // Field positions
  // ******************************************************
  localparam int B_MODE_HI = 7;
  localparam int B_MODE_LO = 6;
  localparam int B_MPE     = 5;
  localparam int B_REN     = 4;
  localparam int B_TB8     = 3;
  localparam int B_RB8     = 2;
  localparam int B_TI      = 1;
  localparam int B_RI      = 0;
  localparam int B_DOUBLE  = 7;
  localparam int B_SRC     = 7;
  localparam logic [7:0] P1_CTRL_MASK = 8'hBF;
  localparam logic [1:0] MODE_FIXED   = 2'h2;

  // ******************************************************
  // Timing
  // ******************************************************
  localparam int         CLK_HZ         = 100_000_000;
  localparam int         BAUD_MIN_BPS   = 300;
  localparam int         BAUD_MAX_BPS   = 38_400;
  localparam logic [9:0] RELOAD_TOP     = 10'h3FF;
  localparam logic [6:0] TICKS_FAST     = 7'h10;
  localparam logic [6:0] TICKS_SLOW     = 7'h20;
  localparam logic [6:0] TICKS_FIX_FAST = 7'h20;
  localparam logic [6:0] TICKS_FIX_SLOW = 7'h40;
  localparam logic [3:0] FRAME8_BITS    = 4'hA;
  localparam logic [3:0] FRAME9_BITS    = 4'hB;
  localparam logic [3:0] DATA8_BITS     = 4'h8;
  localparam logic [3:0] DATA9_BITS     = 4'h9;

  // ******************************************************
  // State types
  // ******************************************************
  typedef enum logic [1:0] {
    TX_IDLE  = 2'b01,
    TX_SHIFT = 2'b10
  } tx_state_t;

  typedef enum logic [2:0] {
    RX_IDLE  = 3'b001,
    RX_START = 3'b010,
    RX_DATA  = 3'b100
  } rx_state_t;

endpackage

// file: design/byte_fifo.sv
// Purpose : Small synchronous FIFO with valid/ready on both sides.
// Assumes : DEPTH is a power of two, at least two.
// Notes   : Input ready is a flop, so a full FIFO refuses at once.
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             i_clk,
  input  wire logic             i_srst,
  input  wire logic             i_in_valid,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_in_ready,
  output logic                  o_out_valid,
  output logic      [WIDTH-1:0] o_out_data,
  input  wire logic             i_out_ready
);
  localparam int PW = $clog2(DEPTH);
  // Cast to the count's width; a PW-bit cast of DEPTH would wrap to zero
  localparam logic [PW:0] FULL_COUNT = (PW+1)'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               wr_ptr;
    logic [PW-1:0]               rd_ptr;
    logic [PW:0]                 count;
    logic                        in_ready;
  } fifo_state_t;

  fifo_state_t r;
  fifo_state_t nxt;
  logic        push;
  logic        pop;

  // Pointer and count update; depth power of two lets pointers wrap
  always_comb begin
    nxt  = r;
    push = i_in_valid && r.in_ready;
    pop  = (r.count != '0) && i_out_ready;
    if (push) begin
      nxt.mem[r.wr_ptr] = i_in_data;
      nxt.wr_ptr        = r.wr_ptr + PW'(1);
    end
    if (pop) begin
      nxt.rd_ptr = r.rd_ptr + PW'(1);
    end
    nxt.count    = r.count + (PW+1)'(push) - (PW+1)'(pop);
    nxt.in_ready = (nxt.count != FULL_COUNT);
  end

  // State register
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      r          <= '0;
      r.in_ready <= 1'b1;
    end else begin
      r <= nxt;
    end
  end

  assign o_in_ready  = r.in_ready;
  assign o_out_valid = (r.count != '0);
  assign o_out_data  = r.mem[r.rd_ptr];
endmodule

// file: design/dual_async_serial_port.sv
// Purpose : Two asynchronous serial ports behind the core's register bus.
// Assumes : Register bus and timer 1 overflow share i_clk; RX pins async.
// Notes   : First port transmit bytes queue in a 4-word FIFO.

module dual_async_serial_port #(
  parameter int TX0_FIFO_DEPTH = 4
) (
  input  wire logic       i_clk,
  input  wire logic       i_srst,
  input  wire logic [7:0] i_sfr_addr,
  input  wire logic       i_sfr_wr,
  input  wire logic [7:0] i_sfr_wdata,
  input  wire logic       i_sfr_rd,
  output logic      [7:0] o_sfr_rdata,
  input  wire logic       i_timer1_ovf,
  input  wire logic       i_port0_rx,
  input  wire logic       i_port1_rx,
  output logic            o_port0_tx,
  output logic            o_port1_tx,
  output logic            o_port0_tx_space
);

  // ******************************************************
  // State
  // ******************************************************
  typedef struct packed {
    logic [7:0]          ctl;
    logic [9:0]          rel;
    logic [9:0]          gen;
    logic [7:0]          rxbuf;
    serial_pkg::tx_state_t tx_st;
    serial_pkg::rx_state_t rx_st;
    logic [6:0]          tcnt;
    logic [6:0]          rcnt;
    logic [3:0]          tbits;
    logic [3:0]          rbits;
    logic [10:0]         tsh;
    logic [8:0]          rsh;
    logic                txo;
  } port_t;

  typedef struct packed {
    port_t [1:0] p;
    logic [1:0]  rx_s1;
    logic [1:0]  rx_s2;
    logic [1:0]  rx_prev;
    logic [7:0]  power;
    logic [7:0]  baud_src;
    logic [7:0]  hold1;
    logic        pend1;
    logic [7:0]  rdata;
  } state_t;

  state_t     r;
  state_t     nxt;
  logic [1:0] wr_ctl;
  logic [1:0] wr_buf;
  logic [1:0] nine;
  logic [1:0] tick;
  logic [1:0] gtick;
  logic [1:0] load;
  logic [1:0] tx_done;
  logic [1:0] rx_finish;
  logic [1:0] rx_done;
  logic [1:0] rx_ninth;
  logic [6:0] nt [2];
  logic [7:0] ld_data [2];
  logic [7:0] rx_byte;
  logic       accept;
  logic       fix_rate;
  logic       fifo_valid;
  logic [7:0] fifo_data;
  logic       fifo_ready;

  // ******************************************************
  // Transmit queue of the first port
  // ******************************************************
  // A write while the queue is full is dropped; o_port0_tx_space warns
  byte_fifo #(
    .WIDTH (8),
    .DEPTH (TX0_FIFO_DEPTH)
  ) u_tx0_fifo (
    .i_clk       (i_clk),
    .i_srst      (i_srst),
    .i_in_valid  (wr_buf[0]),
    .i_in_data   (i_sfr_wdata),
    .o_in_ready  (o_port0_tx_space),
    .o_out_valid (fifo_valid),
    .o_out_data  (fifo_data),
    .i_out_ready (fifo_ready)
  );

  // ******************************************************
  // Next-state logic
  // ******************************************************
  always_comb begin
    nxt       = r;
    rx_byte   = '0;
    accept    = 1'b0;
    tick      = '0;
    gtick     = '0;
    load      = '0;
    tx_done   = '0;
    rx_finish = '0;
    rx_done   = '0;
    rx_ninth  = '0;
    // Decode of the byte-wide register writes
    wr_ctl[0] = i_sfr_wr && (i_sfr_addr == serial_pkg::ADDR_P0_CTRL);
    wr_ctl[1] = i_sfr_wr && (i_sfr_addr == serial_pkg::ADDR_P1_CTRL);
    wr_buf[0] = i_sfr_wr && (i_sfr_addr == serial_pkg::ADDR_P0_BUF);
    wr_buf[1] = i_sfr_wr && (i_sfr_addr == serial_pkg::ADDR_P1_BUF);
    // Frame shape and bit period per port
    fix_rate = (r.p[0].ctl[serial_pkg::B_MODE_HI:serial_pkg::B_MODE_LO]
                == serial_pkg::MODE_FIXED);
    nine[0]  = r.p[0].ctl[serial_pkg::B_MODE_HI];
    nine[1]  = ~r.p[1].ctl[serial_pkg::B_MODE_HI];
    if (fix_rate) begin
      nt[0] = r.power[serial_pkg::B_DOUBLE] ? serial_pkg::TICKS_FIX_FAST
                                            : serial_pkg::TICKS_FIX_SLOW;
    end else begin
      nt[0] = r.power[serial_pkg::B_DOUBLE] ? serial_pkg::TICKS_FAST
                                            : serial_pkg::TICKS_SLOW;
    end
    nt[1]      = serial_pkg::TICKS_FAST;
    ld_data[0] = fifo_data;
    ld_data[1] = r.hold1;
    fifo_ready = 1'b0;

    // Synchronisers: first stage feeds only the second
    nxt.rx_s1   = {i_port1_rx, i_port0_rx};
    nxt.rx_s2   = r.rx_s1;
    nxt.rx_prev = r.rx_s2;

    // Plain registers of the bus
    if (i_sfr_wr) begin
      case (i_sfr_addr)
        serial_pkg::ADDR_POWER_CTRL: nxt.power = i_sfr_wdata;
        serial_pkg::ADDR_BAUD_SRC:   nxt.baud_src = i_sfr_wdata;
        serial_pkg::ADDR_P0_REL_LO:  nxt.p[0].rel[7:0] = i_sfr_wdata;
        serial_pkg::ADDR_P0_REL_HI:  nxt.p[0].rel[9:8] = i_sfr_wdata[1:0];
        serial_pkg::ADDR_P1_REL_LO:  nxt.p[1].rel[7:0] = i_sfr_wdata;
        serial_pkg::ADDR_P1_REL_HI:  nxt.p[1].rel[9:8] = i_sfr_wdata[1:0];
        serial_pkg::ADDR_P1_BUF: begin
          nxt.hold1 = i_sfr_wdata;
          nxt.pend1 = 1'b1;
        end
        default: ;
      endcase
    end

    // Each port runs on its own counters, so both work at once
    for (int k = 0; k < 2; k++) begin
      // Reload generator: counts up to the top, then reloads
      if (r.p[k].gen == serial_pkg::RELOAD_TOP) begin
        nxt.p[k].gen = r.p[k].rel;
        gtick[k]     = 1'b1;
      end else begin
        nxt.p[k].gen = r.p[k].gen + 10'h001;
      end

      // Byte-wide control write; flags only accept zeros
      if (wr_ctl[k]) begin
        nxt.p[k].ctl = i_sfr_wdata;
        nxt.p[k].ctl[serial_pkg::B_TI] =
          r.p[k].ctl[serial_pkg::B_TI] & i_sfr_wdata[serial_pkg::B_TI];
        nxt.p[k].ctl[serial_pkg::B_RI] =
          r.p[k].ctl[serial_pkg::B_RI] & i_sfr_wdata[serial_pkg::B_RI];
      end
    end
    nxt.p[1].ctl = nxt.p[1].ctl & serial_pkg::P1_CTRL_MASK;

    // Bit-tick sources
    if (fix_rate) begin
      tick[0] = 1'b1;
    end else if (r.baud_src[serial_pkg::B_SRC]) begin
      tick[0] = gtick[0];
    end else begin
      tick[0] = i_timer1_ovf;
    end
    tick[1] = gtick[1];
    load[0] = fifo_valid && (r.p[0].tx_st == serial_pkg::TX_IDLE);
    load[1] = r.pend1 && (r.p[1].tx_st == serial_pkg::TX_IDLE);
    fifo_ready = load[0];

    for (int k = 0; k < 2; k++) begin
      // ****** Transmitter ******
      case (r.p[k].tx_st)
        serial_pkg::TX_IDLE: begin
          nxt.p[k].txo = 1'b1;
          if (load[k]) begin
            // Frame right to left: start, data LSB first, ninth, stop
            nxt.p[k].tsh = nine[k]
              ? {1'b1, r.p[k].ctl[serial_pkg::B_TB8], ld_data[k], 1'b0}
              : {2'b11, ld_data[k], 1'b0};
            nxt.p[k].txo   = 1'b0;
            nxt.p[k].tcnt  = '0;
            nxt.p[k].tbits = '0;
            nxt.p[k].tx_st = serial_pkg::TX_SHIFT;
          end
        end
        serial_pkg::TX_SHIFT: begin
          if (tick[k]) begin
            if (r.p[k].tcnt == nt[k] - 7'h01) begin
              nxt.p[k].tcnt  = '0;
              nxt.p[k].tsh   = {1'b1, r.p[k].tsh[10:1]};
              nxt.p[k].txo   = r.p[k].tsh[1];
              nxt.p[k].tbits = r.p[k].tbits + 4'h1;
              if (r.p[k].tbits + 4'h1 == (nine[k] ? serial_pkg::FRAME9_BITS
                                          : serial_pkg::FRAME8_BITS)) begin
                nxt.p[k].txo   = 1'b1;
                nxt.p[k].tx_st = serial_pkg::TX_IDLE;
                tx_done[k]     = 1'b1;
              end
            end else begin
              nxt.p[k].tcnt = r.p[k].tcnt + 7'h01;
            end
          end
        end
        default: begin
          nxt.p[k].tx_st = serial_pkg::TX_IDLE;
          nxt.p[k].txo   = 1'b1;
        end
      endcase
      if (tx_done[k]) begin
        nxt.p[k].ctl[serial_pkg::B_TI] = 1'b1;
      end

      // ****** Receiver ******
      case (r.p[k].rx_st)
        serial_pkg::RX_IDLE: begin
          if (r.p[k].ctl[serial_pkg::B_REN] && r.rx_prev[k]
              && !r.rx_s2[k]) begin
            nxt.p[k].rx_st = serial_pkg::RX_START;
            nxt.p[k].rcnt  = '0;
          end
        end
        serial_pkg::RX_START: begin
          if (tick[k]) begin
            nxt.p[k].rcnt = r.p[k].rcnt + 7'h01;
            if (r.p[k].rcnt == (nt[k] >> 1) - 7'h01) begin
              // A glitch shorter than half a bit is thrown away
              nxt.p[k].rx_st = r.rx_s2[k] ? serial_pkg::RX_IDLE
                                          : serial_pkg::RX_DATA;
              nxt.p[k].rcnt  = '0;
              nxt.p[k].rbits = '0;
            end
          end
        end
        serial_pkg::RX_DATA: begin
          if (tick[k]) begin
            if (r.p[k].rcnt == nt[k] - 7'h01) begin
              nxt.p[k].rcnt = '0;
              if (r.p[k].rbits == (nine[k] ? serial_pkg::DATA9_BITS
                                           : serial_pkg::DATA8_BITS)) begin
                rx_finish[k]   = 1'b1;
                nxt.p[k].rx_st = serial_pkg::RX_IDLE;
              end else begin
                nxt.p[k].rsh   = {r.rx_s2[k], r.p[k].rsh[8:1]};
                nxt.p[k].rbits = r.p[k].rbits + 4'h1;
              end
            end else begin
              nxt.p[k].rcnt = r.p[k].rcnt + 7'h01;
            end
          end
        end
        default: nxt.p[k].rx_st = serial_pkg::RX_IDLE;
      endcase

      // Frame end: in 8-bit frames the stop bit stands in for the ninth
      if (nine[k]) begin
        rx_byte     = r.p[k].rsh[7:0];
        rx_ninth[k] = r.p[k].rsh[8];
      end else begin
        rx_byte     = r.p[k].rsh[8:1];
        rx_ninth[k] = r.rx_s2[k];
      end
      accept = !r.p[k].ctl[serial_pkg::B_MPE] || rx_ninth[k];
      if (rx_finish[k] && accept) begin
        rx_done[k]                      = 1'b1;
        nxt.p[k].rxbuf                  = rx_byte;
        nxt.p[k].ctl[serial_pkg::B_RB8] = rx_ninth[k];
        nxt.p[k].ctl[serial_pkg::B_RI]  = 1'b1;
      end
    end
    if (load[1]) begin
      nxt.pend1 = 1'b0;
    end

    // Registered read data; unmapped addresses read zero
    case (i_sfr_addr)
      serial_pkg::ADDR_POWER_CTRL: nxt.rdata = r.power;
      serial_pkg::ADDR_BAUD_SRC:   nxt.rdata = r.baud_src;
      serial_pkg::ADDR_P0_CTRL:    nxt.rdata = r.p[0].ctl;
      serial_pkg::ADDR_P1_CTRL:    nxt.rdata = r.p[1].ctl;
      serial_pkg::ADDR_P0_BUF:     nxt.rdata = r.p[0].rxbuf;
      serial_pkg::ADDR_P1_BUF:     nxt.rdata = r.p[1].rxbuf;
      serial_pkg::ADDR_P0_REL_LO:  nxt.rdata = r.p[0].rel[7:0];
      serial_pkg::ADDR_P0_REL_HI:  nxt.rdata = {6'h00, r.p[0].rel[9:8]};
      serial_pkg::ADDR_P1_REL_LO:  nxt.rdata = r.p[1].rel[7:0];
      serial_pkg::ADDR_P1_REL_HI:  nxt.rdata = {6'h00, r.p[1].rel[9:8]};
      default:                     nxt.rdata = serial_pkg::RST_BYTE;
    endcase
    if (!i_sfr_rd) begin
      nxt.rdata = r.rdata;
    end
  end

  // ******************************************************
  // State register
  // ******************************************************
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      r <= '0;
      for (int k = 0; k < 2; k++) begin
        r.p[k].rel   <= serial_pkg::RST_RELOAD;
        r.p[k].tx_st <= serial_pkg::TX_IDLE;
        r.p[k].rx_st <= serial_pkg::RX_IDLE;
        r.p[k].txo   <= 1'b1;
      end
      r.rx_s1   <= 2'h3;
      r.rx_s2   <= 2'h3;
      r.rx_prev <= 2'h3;
    end else begin
      r <= nxt;
    end
  end

  assign o_sfr_rdata = r.rdata;
  assign o_port0_tx  = r.p[0].txo;
  assign o_port1_tx  = r.p[1].txo;

  // ******************************************************
  // Assertions
  // ******************************************************
  property p_tx_idle_high;
    @(posedge i_clk) disable iff (i_srst)
    (r.p[0].tx_st == serial_pkg::TX_IDLE) |-> o_port0_tx;
  endproperty
  a_tx_idle_high: assert property (p_tx_idle_high)
    else $error("port0 TX low while idle");

  property p_write_starts;
    @(posedge i_clk) disable iff (i_srst)
    (wr_buf[1] && !r.pend1 && r.p[1].tx_st == serial_pkg::TX_IDLE)
      |=> ##1 (!o_port1_tx && r.p[1].tx_st == serial_pkg::TX_SHIFT);
  endproperty
  a_write_starts: assert property (p_write_starts)
    else $error("port1 write did not start a frame");

  property p_flag_clear;
    @(posedge i_clk) disable iff (i_srst)
    (wr_ctl[0] && !i_sfr_wdata[serial_pkg::B_RI] && !rx_done[0])
      |=> !r.p[0].ctl[serial_pkg::B_RI];
  endproperty
  a_flag_clear: assert property (p_flag_clear)
    else $error("writing zero did not clear the receive flag");

  property p_flag_keep;
    @(posedge i_clk) disable iff (i_srst)
    (wr_ctl[0] && i_sfr_wdata[serial_pkg::B_TI] && !tx_done[0])
      |=> (r.p[0].ctl[serial_pkg::B_TI] ==
           $past(r.p[0].ctl[serial_pkg::B_TI]));
  endproperty
  a_flag_keep: assert property (p_flag_keep)
    else $error("writing one changed the transmit flag");

  property p_tx_done_sets;
    @(posedge i_clk) disable iff (i_srst)
    tx_done[0] |=> r.p[0].ctl[serial_pkg::B_TI]
      ##1 (r.p[0].ctl[serial_pkg::B_TI]
           || $past(wr_ctl[0] && !i_sfr_wdata[serial_pkg::B_TI]));
  endproperty
  a_tx_done_sets: assert property (p_tx_done_sets)
    else $error("transmit flag not set and held after frame");

  property p_rx_done_sets;
    @(posedge i_clk) disable iff (i_srst)
    rx_done[1] |=> (r.p[1].ctl[serial_pkg::B_RI]
                    && r.p[1].rxbuf == $past(rx_byte));
  endproperty
  a_rx_done_sets: assert property (p_rx_done_sets)
    else $error("receive flag or buffer not updated");

  property p_read_buffer;
    @(posedge i_clk) disable iff (i_srst)
    (i_sfr_rd && i_sfr_addr == serial_pkg::ADDR_P0_BUF)
      |=> (o_sfr_rdata == $past(r.p[0].rxbuf));
  endproperty
  a_read_buffer: assert property (p_read_buffer)
    else $error("data register read returned wrong byte");

  property p_mpe_blocks;
    @(posedge i_clk) disable iff (i_srst)
    (rx_finish[0] && nine[0] && !rx_ninth[0] && !wr_ctl[0]
     && r.p[0].ctl[serial_pkg::B_MPE])
      |=> (r.p[0].ctl[serial_pkg::B_RI] ==
           $past(r.p[0].ctl[serial_pkg::B_RI]));
  endproperty
  a_mpe_blocks: assert property (p_mpe_blocks)
    else $error("data frame raised flag in multiprocessor mode");

  property p_reload;
    @(posedge i_clk) disable iff (i_srst)
    (r.p[0].gen == serial_pkg::RELOAD_TOP)
      |=> (r.p[0].gen == $past(r.p[0].rel));
  endproperty
  a_reload: assert property (p_reload)
    else $error("baud generator did not reload");
endmodule

// file: sim/serial_node.sv
// Purpose: Far-side serial node for one port of the block.
// Assumes: Bench sets bit period in clocks and frame length.
// Notes  : Line idles high, as a pulled-up link would.
module serial_node (
  input  wire logic i_clk,
  input  wire logic i_line,
  output logic      o_line
);
  timeunit 1ns;
  timeprecision 1ps;
  int          period = 16;
  int          nbits  = 10;
  int          frames = 0;
  logic [10:0] got    = '0;
  initial o_line = 1'b1;
  // Start low, bits LSB first, stop high; moves on falling edges
  task automatic send(input logic [8:0] d, input int n);
    for (int i = -1; i <= n; i++) begin
      o_line = (i < 0) ? 1'b0 : (i == n) ? 1'b1 : d[i];
      repeat (period) @(negedge i_clk);
    end
  endtask
  // Stop at mid stop bit so a back-to-back start edge is not missed
  always begin
    @(negedge i_line);
    got = '0;
    repeat (period / 2) @(posedge i_clk);
    for (int i = 0; i < nbits; i++) begin
      if (i > 0) repeat (period) @(posedge i_clk);
      got[i] = i_line;
    end
    frames++;
  end
endmodule

// file: sim/tb_top.sv
// Purpose: Self-checking bench of the dual serial port block.
// Assumes: Reload 0x3FF gives one generator tick per clock.
// Notes  : Bit periods are worked out from the mode and rate bits.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, srst, wr, rd, t1, n9;
  logic        tx0, tx1, rx0, rx1, space;
  logic [7:0]  addr, wdata, v, d, b;
  logic [7:0]  rdata;
  logic [7:0]  q[5];
  logic [31:0] seed        = 32'h5e2d_701f;
  int          num_errors  = 0;
  int          comparisons = 0;

  dual_async_serial_port i_dut (.i_clk(clk), .i_srst(srst),
    .i_sfr_addr(addr), .i_sfr_wr(wr), .i_sfr_wdata(wdata),
    .i_sfr_rd(rd), .o_sfr_rdata(rdata), .i_timer1_ovf(t1),
    .i_port0_rx(rx0), .i_port1_rx(rx1), .o_port0_tx(tx0),
    .o_port1_tx(tx1), .o_port0_tx_space(space));
  serial_node i_n0 (.i_clk(clk), .i_line(tx0), .o_line(rx0));
  serial_node i_n1 (.i_clk(clk), .i_line(tx1), .o_line(rx1));

  // ****************************************
  // Clock, timer pulses and helpers
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Timer 1 overflow every other clock: bit period 32 when chosen
  always @(negedge clk) t1 <= srst ? 1'b0 : ~t1;

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // Frame as sampled: start, data, ninth if any, stop
  function automatic logic [10:0] frame(input logic [7:0] x,
                                        input logic n, input logic nine);
    return nine ? {1'b1, n, x, 1'b0} : {2'b01, x, 1'b0};
  endfunction
  task automatic check(input logic [10:0] seen, input logic [10:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] x);
    @(negedge clk);
    addr = a;
    wdata = x;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    @(negedge clk);
    v = rdata;
  endtask
  // Bounded wait for the far node to count n frames
  task automatic wait_frame(input int p, input int n);
    int k;
    k = 0;
    while ((p ? i_n1.frames : i_n0.frames) < n) begin
      @(negedge clk);
      k++;
      if (k > 5000) begin
        num_errors++;
        $display("Error at %0t: frame wait timed out", $time);
        stop_test();
      end
    end
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    srst = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    repeat (4) @(negedge clk);
    srst = 1'b0;
    check(space, 1'b1);
    rd_reg(serial_pkg::ADDR_P0_REL_LO);
    check(v, 8'hD9);
    rd_reg(8'h01);
    check(v, 8'h00);
    wr_reg(serial_pkg::ADDR_P0_REL_LO, 8'hFF);
    wr_reg(serial_pkg::ADDR_P1_REL_LO, 8'hFF);
    wr_reg(serial_pkg::ADDR_POWER_CTRL, 8'h80);
    // Generators count up from zero once before the new reload applies
    repeat (1024) @(negedge clk);
    $display("Done: reset and setup");
    // Second port, 8-bit frames, both directions at once
    wr_reg(serial_pkg::ADDR_P1_CTRL, 8'h90);
    seed = lfsr(seed);
    d = seed[7:0];
    b = seed[15:8];
    fork
      i_n1.send({1'b1, b}, 8);
      wr_reg(serial_pkg::ADDR_P1_BUF, d);
    join
    wait_frame(1, 1);
    check(i_n1.got, frame(d, 1'b0, 1'b0));
    repeat (16) @(negedge clk);
    rd_reg(serial_pkg::ADDR_P1_BUF);
    check(v, b);
    rd_reg(serial_pkg::ADDR_P1_CTRL);
    check(v, 8'h97);
    wr_reg(serial_pkg::ADDR_P1_CTRL, 8'hFD);
    rd_reg(serial_pkg::ADDR_P1_CTRL);
    check(v, 8'hBD);
    // Second port, 9-bit frame carrying a set ninth bit
    i_n1.nbits = 11;
    wr_reg(serial_pkg::ADDR_P1_CTRL, 8'h18);
    wr_reg(serial_pkg::ADDR_P1_BUF, b);
    wait_frame(1, 2);
    check(i_n1.got, frame(b, 1'b1, 1'b1));
    $display("Done: second port");
    // First port, modes 1 to 3, timer 1 in mode 1
    for (int m = 1; m < 4; m++) begin
      seed = lfsr(seed);
      d = seed[7:0];
      n9 = seed[8];
      i_n0.period = (m == 3) ? 16 : 32;
      i_n0.nbits = (m == 1) ? 10 : 11;
      wr_reg(serial_pkg::ADDR_BAUD_SRC, (m == 3) ? 8'h80 : 8'h00);
      wr_reg(serial_pkg::ADDR_P0_CTRL, {2'(m), 2'b01, n9, 3'b000});
      wr_reg(serial_pkg::ADDR_P0_BUF, d);
      wait_frame(0, m);
      check(i_n0.got, frame(d, n9, m > 1));
      repeat (32) @(negedge clk);
      rd_reg(serial_pkg::ADDR_P0_CTRL);
      check(v[1], 1'b1);
    end
    $display("Done: first port modes");
    // Address frame passes the filter, data frame does not
    wr_reg(serial_pkg::ADDR_P0_CTRL, 8'hF0);
    i_n0.send({1'b1, d}, 9);
    i_n0.send({1'b0, ~d}, 9);
    rd_reg(serial_pkg::ADDR_P0_CTRL);
    check(v, 8'hF5);
    rd_reg(serial_pkg::ADDR_P0_BUF);
    check(v, d);
    wr_reg(serial_pkg::ADDR_P0_CTRL, 8'hD0);
    i_n0.send({1'b0, b}, 9);
    rd_reg(serial_pkg::ADDR_P0_CTRL);
    check(v, 8'hD1);
    $display("Done: multiprocessor filter");
    // Fill the transmit queue until it refuses, then drain it
    foreach (q[k]) begin
      seed = lfsr(seed);
      q[k] = seed[7:0];
      wr_reg(serial_pkg::ADDR_P0_BUF, q[k]);
    end
    check(space, 1'b0);
    foreach (q[k]) begin
      wait_frame(0, 4 + k);
      check(i_n0.got, frame(q[k], 1'b0, 1'b1));
    end
    repeat (16) @(negedge clk);
    check(space, 1'b1);
    $display("Done: transmit queue");
    stop_test();
  end
endmodule
